// ---- verilog/keyword_parser_defines.vh ----
// constants for the command interpreter: characters, table sizes, limits, codes
`ifndef KEYWORD_PARSER_DEFINES_VH
`define KEYWORD_PARSER_DEFINES_VH
`define CH_NL 8'h0A
`define CH_SPACE 8'h20
`define CH_COLON 8'h3A
`define CH_SEMI 8'h3B
`define CH_QUERY 8'h3F
`define CH_STAR 8'h2A
`define CH_A_UP 8'h41
`define CH_Z_UP 8'h5A
`define CH_A_LO 8'h61
`define CH_Z_LO 8'h7A
`define CH_0 8'h30
`define CH_9 8'h39
`define CASE_BIT 8'h20
`define KW_MAX 4'hC
`define KW_COUNT 5'h12
`define LIST_DEPTH 250
`define LIST_AW 8
`define DWELL_MIN 16'h0001
`define DWELL_MAX 16'hFFFF
`define TEN_MS_UNITS 16'h0064
`define TRG_LEN 4'h3
`define COMMON_TRG "TRG"
`define DEC_BASE 20'h0000A
// register indices
`define A_ARMED 4'h0
`define A_OPER_COND 4'h1
`define A_OPER_EN 4'h2
`define A_OPER_EVT 4'h3
`define A_QUES_COND 4'h4
`define A_QUES_EN 4'h5
`define A_QUES_EVT 4'h6
`define A_ERROR 4'h7
`define A_LIST_IDX 4'h8
`define A_LIST_CURR 4'h9
`define A_LIST_VOLT 4'hA
`define A_LIST_TIME 4'hB
`define A_CAL_STAT 4'hC
`define A_MEAS 4'hD
`define A_CAL_PWD 4'hE
// error codes
`define ERR_NONE 8'h00
`define ERR_KEYWORD 8'h71
`define ERR_SYNTAX 8'h66
`define ERR_RANGE 8'h8A
`define ERR_CAL 8'h8C
// keyword identifiers
`define KID_NONE 5'h1F
`define KID_INIT 5'h00
`define KID_TRIG 5'h01
`define KID_LIST 5'h02
`define KID_MEAS 5'h03
`define KID_CAL 5'h04
`define KID_STAT 5'h05
`define KID_VOLT 5'h06
`define KID_CURR 5'h07
`define KID_DWEL 5'h08
`define KID_ZERO 5'h09
`define KID_LEV 5'h0A
`define KID_SAVE 5'h0B
`define KID_PASS 5'h0C
`define KID_OPER 5'h0D
`define KID_QUES 5'h0E
`define KID_ENAB 5'h0F
`define KID_IMM 5'h10
`define KID_MODE 5'h11
// calibration step bits
`define CAL_VZ 0
`define CAL_VF 1
`define CAL_IZ 2
`define CAL_IF 3
`endif

// ---- verilog/keyword_parser.v ----
// command interpreter: keyword matching, triggers, list store, status, calibration
`timescale 1ns/1ps
`default_nettype none
`include "keyword_parser_defines.vh"
// Function
// - armed trigger commands perform trigger action
// - unarmed trigger commands are silently discarded
// - volatile list of 250 current/voltage/time
// - list time accepted from 0.01 to 655.35s
// - operation and questionable condition/enable/event groups
// - calibration entry needs correct password first
// - one calibration session, panel or remote only
// - voltage full-scale calibration coefficient written to nonvolatile store
// - zero and full-scale steps; partial save allowed
// - message unit is keyword plus terminator
// - one space-separated numeric or string parameter
// - keywords up to four letters: full form
// - longer keywords: four or three letter short
// - other truncations flag a keyword error
// - keyword matching ignores letter case
// - colon steps to next keyword level
// - measurement query returns output voltage and current
// - newline 0A terminates and triggers action
// - semicolons separate message units
// - terminator or leading colon resets path
// - trailing question mark makes a query
module keyword_parser (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  input wire get_i,
  input wire panel_cal_i,
  input wire [15:0] meas_volt_i,
  input wire [15:0] meas_curr_i,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  output reg trigger_o,
  output reg query_o,
  output reg [31:0] resp_o,
  output reg cal_busy_o,
  output reg nv_we_o,
  output reg [3:0] nv_addr_o,
  output reg [15:0] nv_data_o,
  output reg [7:0] error_o
);
  // parser states, one-hot
  localparam S_KEY = 4'b0001;
  localparam S_PARAM = 4'b0010;
  localparam S_SKIP = 4'b0100;
  localparam S_DONE = 4'b1000;
  // pin synchroniser for the group execute trigger: three stages, two must agree
  reg [2:0] get_sync_reg;
  reg get_level_reg;
  reg [3:0] state_reg;
  reg [7:0] kw_buf_reg [0:11];
  reg [3:0] kw_len_reg;
  reg [4:0] path_reg [0:1];
  reg [1:0] depth_reg;
  reg is_query_reg;
  reg star_reg;
  reg param_ovf_reg;
  reg [4:0] branch_reg;
  reg has_param_reg;
  reg [15:0] param_reg;
  reg param_num_reg;
  reg armed_reg;
  reg [15:0] oper_cond_reg, oper_en_reg, oper_evt_reg;
  reg [15:0] ques_cond_reg, ques_en_reg, ques_evt_reg;
  reg [15:0] list_curr_reg [0:`LIST_DEPTH-1];
  reg [15:0] list_volt_reg [0:`LIST_DEPTH-1];
  reg [15:0] list_time_reg [0:`LIST_DEPTH-1];
  reg [`LIST_AW-1:0] list_idx_reg;
  reg [15:0] cal_pwd_reg;
  reg cal_unlock_reg, cal_mode_reg, cal_remote_reg;
  reg [3:0] cal_steps_reg;
  reg [15:0] cal_coef_reg [0:3];
  wire [7:0] ch_up;
  wire is_alpha, is_digit;
  integer i;
  parameter [15:0] CAL_PASSWORD = 16'h1234; // arbitrary default access code

  // fold case so one table serves every spelling
  function [7:0] upper;
    input [7:0] c;
    begin
      if (c >= `CH_A_LO && c <= `CH_Z_LO)
        upper = c & ~`CASE_BIT;
      else
        upper = c;
    end
  endfunction

  // long-form table; short length derived from the fourth letter
  function [95:0] long_form;
    input [4:0] k;
    begin
      case (k)
        `KID_INIT: long_form = "INITIATE";
        `KID_TRIG: long_form = "TRIGGER";
        `KID_LIST: long_form = "LIST";
        `KID_MEAS: long_form = "MEASURE";
        `KID_CAL: long_form = "CALIBRATE";
        `KID_STAT: long_form = "STATUS";
        `KID_VOLT: long_form = "VOLTAGE";
        `KID_CURR: long_form = "CURRENT";
        `KID_DWEL: long_form = "DWELL";
        `KID_ZERO: long_form = "ZERO";
        `KID_LEV: long_form = "LEVEL";
        `KID_SAVE: long_form = "SAVE";
        `KID_PASS: long_form = "PASSWORD";
        `KID_OPER: long_form = "OPERATION";
        `KID_QUES: long_form = "QUESTIONABLE";
        `KID_ENAB: long_form = "ENABLE";
        `KID_IMM: long_form = "IMMEDIATE";
        `KID_MODE: long_form = "MODE";
        default: long_form = 96'h0;
      endcase
    end
  endfunction

  // letter j (0 first) of a right-justified string of length n
  function [7:0] letter;
    input [95:0] s;
    input [3:0] n;
    input [3:0] j;
    reg [6:0] sh;
    begin
      sh = {(n - j - 4'h1), 3'b000};
      letter = s[sh +: 8];
    end
  endfunction

  function [3:0] str_len;
    input [95:0] s;
    integer b;
    begin
      str_len = 4'h0;
      for (b = 0; b < 12; b = b + 1)
        if (s[b*8 +: 8] != 8'h00)
          str_len = b[3:0] + 4'h1;
    end
  endfunction

  function vowel;
    input [7:0] c;
    begin
      vowel = (c == "A") || (c == "E") || (c == "I") || (c == "O") || (c == "U");
    end
  endfunction

  // match buffered keyword against table: long form or exact short form only
  reg [4:0] match_id;
  reg [95:0] lf;
  reg [3:0] ln, sn;
  reg hit;
  integer k, j;
  always @*
  begin
    match_id = `KID_NONE;
    lf = 96'h0;
    ln = 4'h0;
    sn = 4'h0;
    hit = 1'b0;
    for (k = 0; k < `KW_COUNT; k = k + 1)
    begin
      lf = long_form(k[4:0]);
      ln = str_len(lf);
      if (ln <= 4'h4)
        sn = ln;
      else if (vowel(letter(lf, ln, 4'h3)))
        sn = 4'h3;
      else
        sn = 4'h4;
      if (kw_len_reg == ln || kw_len_reg == sn)
      begin
        hit = 1'b1;
        for (j = 0; j < `KW_MAX; j = j + 1)
          if (j < kw_len_reg && kw_buf_reg[j] != letter(lf, ln, j[3:0]))
            hit = 1'b0;
        if (hit)
          match_id = k[4:0];
      end
    end
    // common commands carry a leading star and have no short form
    if (star_reg)
      match_id = `KID_NONE;
    if (star_reg && kw_len_reg == `TRG_LEN &&
      {kw_buf_reg[0], kw_buf_reg[1], kw_buf_reg[2]} == `COMMON_TRG)
      match_id = `KID_TRIG;
  end

  assign ch_up = upper(rx_data_i);
  assign is_alpha = ch_up >= `CH_A_UP && ch_up <= `CH_Z_UP;
  assign is_digit = rx_data_i >= `CH_0 && rx_data_i <= `CH_9;

  // synchroniser; first stage read only by the second
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      get_sync_reg <= 3'b000;
      get_level_reg <= 1'b0;
    end
    else
    begin
      get_sync_reg <= {get_sync_reg[1:0], get_i};
      if (get_sync_reg[2] == get_sync_reg[1])
        get_level_reg <= get_sync_reg[2];
    end
  end
  wire get_rise = (get_sync_reg[2] == get_sync_reg[1]) && get_sync_reg[2] && !get_level_reg;

  // flags of the unit just closed; the unit acts on a separator or terminator
  wire unit_end = rx_valid_i && (rx_data_i == `CH_SEMI || rx_data_i == `CH_NL) &&
    (state_reg == S_KEY || state_reg == S_PARAM);
  wire kw_close = rx_valid_i && state_reg == S_KEY && kw_len_reg != 4'h0 &&
    (rx_data_i == `CH_COLON || rx_data_i == `CH_SPACE || rx_data_i == `CH_QUERY || unit_end);
  wire [4:0] leaf = kw_close ? match_id : path_reg[depth_reg[0]];
  wire [4:0] top = path_reg[0];
  wire [15:0] pval = has_param_reg ? param_reg : 16'h0000;
  // wide accumulator so an oversized count is caught instead of wrapping
  wire [19:0] param_acc = {4'h0, param_reg} * `DEC_BASE + {12'h000, rx_data_i - `CH_0};
  wire oper_evt_set = (oper_cond_reg & oper_en_reg) != 16'h0000;
  wire ques_evt_set = (ques_cond_reg & ques_en_reg) != 16'h0000;

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= S_KEY;
      kw_len_reg <= 4'h0;
      depth_reg <= 2'b00;
      path_reg[0] <= `KID_NONE;
      path_reg[1] <= `KID_NONE;
      is_query_reg <= 1'b0;
      has_param_reg <= 1'b0;
      param_reg <= 16'h0000;
      param_num_reg <= 1'b0;
      star_reg <= 1'b0;
      param_ovf_reg <= 1'b0;
      branch_reg <= `KID_NONE;
      armed_reg <= 1'b0;
      oper_cond_reg <= 16'h0000;
      oper_en_reg <= 16'h0000;
      oper_evt_reg <= 16'h0000;
      ques_cond_reg <= 16'h0000;
      ques_en_reg <= 16'h0000;
      ques_evt_reg <= 16'h0000;
      list_idx_reg <= 8'h00;
      cal_pwd_reg <= 16'h0000;
      cal_unlock_reg <= 1'b0;
      cal_mode_reg <= 1'b0;
      cal_remote_reg <= 1'b0;
      cal_steps_reg <= 4'h0;
      trigger_o <= 1'b0;
      query_o <= 1'b0;
      resp_o <= 32'h00000000;
      nv_we_o <= 1'b0;
      nv_addr_o <= 4'h0;
      nv_data_o <= 16'h0000;
      error_o <= `ERR_NONE;
      rdata_o <= 16'h0000;
      for (i = 0; i < 4; i = i + 1)
        cal_coef_reg[i] <= 16'h0000;
      for (i = 0; i < `KW_MAX; i = i + 1)
        kw_buf_reg[i] <= 8'h00;
    end
    else
    begin
      trigger_o <= 1'b0;
      query_o <= 1'b0;
      nv_we_o <= 1'b0;
      // event bits: set wins over a software clear in the same cycle
      if (wr_i && addr_i == `A_OPER_EVT)
        oper_evt_reg <= (oper_evt_reg & ~wdata_i) | (oper_cond_reg & oper_en_reg);
      else if (oper_evt_set)
        oper_evt_reg <= oper_evt_reg | (oper_cond_reg & oper_en_reg);
      if (wr_i && addr_i == `A_QUES_EVT)
        ques_evt_reg <= (ques_evt_reg & ~wdata_i) | (ques_cond_reg & ques_en_reg);
      else if (ques_evt_set)
        ques_evt_reg <= ques_evt_reg | (ques_cond_reg & ques_en_reg);
      ques_cond_reg <= {15'h0000, error_o != `ERR_NONE};
      oper_cond_reg <= {14'h0000, armed_reg, cal_mode_reg};
      if (get_rise && armed_reg)
        trigger_o <= 1'b1;
      // register port writes
      if (wr_i)
      begin
        case (addr_i)
          `A_ARMED: armed_reg <= wdata_i[0];
          `A_OPER_EN: oper_en_reg <= wdata_i;
          `A_QUES_EN: ques_en_reg <= wdata_i;
          `A_ERROR: error_o <= `ERR_NONE;
          `A_LIST_IDX: list_idx_reg <= wdata_i[7:0];
          `A_CAL_PWD: cal_pwd_reg <= wdata_i;
          default: ;
        endcase
      end
      // register port reads; data one cycle after the strobe
      if (rd_i)
      begin
        case (addr_i)
          `A_ARMED: rdata_o <= {15'h0000, armed_reg};
          `A_OPER_COND: rdata_o <= oper_cond_reg;
          `A_OPER_EN: rdata_o <= oper_en_reg;
          `A_OPER_EVT: rdata_o <= oper_evt_reg;
          `A_QUES_COND: rdata_o <= ques_cond_reg;
          `A_QUES_EN: rdata_o <= ques_en_reg;
          `A_QUES_EVT: rdata_o <= ques_evt_reg;
          `A_ERROR: rdata_o <= {8'h00, error_o};
          `A_LIST_IDX: rdata_o <= {8'h00, list_idx_reg};
          `A_LIST_CURR: rdata_o <= list_curr_reg[list_idx_reg];
          `A_LIST_VOLT: rdata_o <= list_volt_reg[list_idx_reg];
          `A_LIST_TIME: rdata_o <= list_time_reg[list_idx_reg];
          `A_CAL_STAT: rdata_o <= {10'h000, cal_remote_reg, cal_mode_reg, cal_steps_reg};
          `A_MEAS: rdata_o <= meas_volt_i;
          default: rdata_o <= 16'h0000;
        endcase
      end
      // character stream
      if (rx_valid_i)
      begin
        case (state_reg)
          S_KEY:
          begin
            if (kw_close)
              star_reg <= 1'b0;
            if (is_alpha && kw_len_reg < `KW_MAX)
            begin
              kw_buf_reg[kw_len_reg] <= ch_up;
              kw_len_reg <= kw_len_reg + 4'h1;
            end
            else if (rx_data_i == `CH_COLON && kw_len_reg == 4'h0)
              depth_reg <= 2'b00;
            else if (kw_close && match_id == `KID_NONE)
            begin
              error_o <= `ERR_KEYWORD;
              state_reg <= (rx_data_i == `CH_NL) ? S_KEY : S_SKIP;
              depth_reg <= 2'b00;
              kw_len_reg <= 4'h0;
            end
            else if (kw_close)
            begin
              path_reg[depth_reg[0]] <= match_id;
              // keep the level above the leaf; the leaf overwrites it
              if (depth_reg != 2'b00)
                branch_reg <= path_reg[1];
              kw_len_reg <= 4'h0;
              if (rx_data_i == `CH_COLON && depth_reg == 2'b00)
                depth_reg <= 2'b01;
              else if (rx_data_i == `CH_COLON)
                depth_reg <= 2'b01;
              if (rx_data_i == `CH_QUERY)
                is_query_reg <= 1'b1;
              if (rx_data_i == `CH_SPACE)
              begin
                state_reg <= S_PARAM;
                param_reg <= 16'h0000;
                param_num_reg <= 1'b1;
              end
            end
            else if (rx_data_i == `CH_STAR && kw_len_reg == 4'h0)
              star_reg <= 1'b1;
            else if (rx_data_i == `CH_SPACE && is_query_reg)
            begin
              state_reg <= S_PARAM;
              param_reg <= 16'h0000;
              param_num_reg <= 1'b1;
            end
            else if (!unit_end && rx_data_i != `CH_STAR)
            begin
              error_o <= `ERR_SYNTAX;
              state_reg <= (rx_data_i == `CH_NL) ? S_KEY : S_SKIP;
              kw_len_reg <= 4'h0;
            end
          end
          S_PARAM:
          begin
            if (is_digit)
            begin
              param_reg <= param_acc[15:0];
              if (param_acc[19:16] != 4'h0)
                param_ovf_reg <= 1'b1;
              has_param_reg <= 1'b1;
            end
            else if (!unit_end && rx_data_i != `CH_SPACE)
            begin
              param_num_reg <= 1'b0; // string parameter
              has_param_reg <= 1'b1;
              param_reg <= {param_reg[7:0], ch_up};
            end
          end
          S_SKIP:
            if (rx_data_i == `CH_NL)
              state_reg <= S_KEY;
          default: state_reg <= S_KEY;
        endcase
        // act on a complete unit
        if (unit_end && !(kw_close && match_id == `KID_NONE))
        begin
          state_reg <= S_KEY;
          is_query_reg <= 1'b0;
          has_param_reg <= 1'b0;
          star_reg <= 1'b0;
          param_ovf_reg <= 1'b0;
          if (rx_data_i == `CH_NL)
          begin
            depth_reg <= 2'b00;
            path_reg[0] <= `KID_NONE;
          end
          if (top == `KID_TRIG || (depth_reg == 2'b00 && leaf == `KID_TRIG))
            trigger_o <= armed_reg;
          if (top == `KID_INIT || (depth_reg == 2'b00 && leaf == `KID_INIT))
            armed_reg <= 1'b1;
          if (top == `KID_MEAS && (is_query_reg || rx_data_i == `CH_NL))
          begin
            query_o <= 1'b1;
            resp_o <= {meas_volt_i, meas_curr_i};
          end
          if (top == `KID_LIST && leaf == `KID_DWEL && has_param_reg)
          begin
            if (pval >= `DWELL_MIN && pval <= `DWELL_MAX && !param_ovf_reg)
              list_time_reg[list_idx_reg] <= pval;
            else
              error_o <= `ERR_RANGE;
          end
          if (top == `KID_LIST && leaf == `KID_VOLT && has_param_reg)
            list_volt_reg[list_idx_reg] <= pval;
          if (top == `KID_LIST && leaf == `KID_CURR && has_param_reg)
            list_curr_reg[list_idx_reg] <= pval;
          if (top == `KID_STAT && leaf == `KID_ENAB && has_param_reg)
          begin
            if (branch_reg == `KID_QUES || leaf == `KID_QUES)
              ques_en_reg <= pval;
            else
              oper_en_reg <= pval;
          end
          // calibration: password, exclusive session, steps, save
          if (top == `KID_CAL && leaf == `KID_PASS)
          begin
            if (pval == CAL_PASSWORD && !panel_cal_i)
            begin
              cal_mode_reg <= 1'b1;
              cal_remote_reg <= 1'b1;
              cal_steps_reg <= 4'h0;
            end
            else
              error_o <= `ERR_CAL;
          end
          if (top == `KID_CAL && cal_mode_reg && cal_remote_reg && leaf != `KID_PASS)
          begin
            if (leaf == `KID_ZERO && path_reg[1] == `KID_VOLT)
            begin
              cal_coef_reg[`CAL_VZ] <= meas_volt_i;
              cal_steps_reg[`CAL_VZ] <= 1'b1;
            end
            if (leaf == `KID_LEV && path_reg[1] == `KID_VOLT)
            begin
              cal_coef_reg[`CAL_VF] <= meas_volt_i - cal_coef_reg[`CAL_VZ];
              cal_steps_reg[`CAL_VF] <= 1'b1;
            end
            if (leaf == `KID_ZERO && path_reg[1] == `KID_CURR)
            begin
              cal_coef_reg[`CAL_IZ] <= meas_curr_i;
              cal_steps_reg[`CAL_IZ] <= 1'b1;
            end
            if (leaf == `KID_LEV && path_reg[1] == `KID_CURR)
            begin
              cal_coef_reg[`CAL_IF] <= meas_curr_i - cal_coef_reg[`CAL_IZ];
              cal_steps_reg[`CAL_IF] <= 1'b1;
            end
            if (leaf == `KID_SAVE)
            begin
              cal_mode_reg <= 1'b0; // save either pair alone
              cal_remote_reg <= 1'b0;
              nv_we_o <= 1'b1;
              nv_addr_o <= cal_steps_reg;
              nv_data_o <= cal_coef_reg[`CAL_VF];
            end
          end
          else if (top == `KID_CAL && leaf != `KID_PASS && panel_cal_i)
            error_o <= `ERR_CAL;
        end
      end
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cal_busy_o <= 1'b0;
    else
      cal_busy_o <= cal_mode_reg;
  end
endmodule
`default_nettype wire

// ---- tb/keyword_parser_asserts.sv ----
// concurrent port checks for the command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "keyword_parser_defines.vh"
module keyword_parser_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic panel_cal_i,
  input wire logic [15:0] meas_volt_i,
  input wire logic [15:0] meas_curr_i,
  input wire logic [3:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic trigger_o,
  input wire logic query_o,
  input wire logic [31:0] resp_o,
  input wire logic cal_busy_o,
  input wire logic [7:0] error_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus reads of the readback place and of the unmapped place
  sequence s_meas_rd;
    rd_i && addr_i == `A_MEAS;
  endsequence
  sequence s_free_rd;
    rd_i && addr_i == 4'hF;
  endsequence
  AST_TRIG_PULSE: assert property (trigger_o |=> !trigger_o)
    else $error("trigger pulse too long");
  AST_QUERY_PULSE: assert property (query_o |=> !query_o)
    else $error("query pulse too long");
  AST_QUERY_RESP: assert property (query_o |-> resp_o == {meas_volt_i, meas_curr_i})
    else $error("response does not carry readback");
  AST_MEAS_READ: assert property (s_meas_rd |=> rdata_o == $past(meas_volt_i))
    else $error("readback register wrong");
  AST_FREE_READ: assert property (s_free_rd |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  AST_CAL_PANEL: assert property ($rose(cal_busy_o) |-> !$past(panel_cal_i))
    else $error("remote session opened during panel session");
  AST_ERR_CLEAR: assert property (wr_i && addr_i == `A_ERROR && !rx_valid_i |=>
    error_o == `ERR_NONE)
    else $error("error code not cleared");
  AST_ERR_CODES: assert property (error_o inside {`ERR_NONE, `ERR_KEYWORD, `ERR_SYNTAX,
    `ERR_RANGE, `ERR_CAL})
    else $error("unknown error code");
  AST_RESET_QUIET: assert property ($fell(rst_i) |-> !trigger_o && !query_o && !cal_busy_o
    && error_o == `ERR_NONE)
    else $error("outputs active after reset");
endmodule
bind keyword_parser keyword_parser_asserts keyword_parser_asserts_i (.clk_i(clk_i),
  .rst_i(rst_i), .rx_valid_i(rx_valid_i), .panel_cal_i(panel_cal_i),
  .meas_volt_i(meas_volt_i), .meas_curr_i(meas_curr_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .trigger_o(trigger_o), .query_o(query_o),
  .resp_o(resp_o), .cal_busy_o(cal_busy_o), .error_o(error_o));
`default_nettype wire

// ---- tb/host_model.sv ----
// host controller model: sends program message lines a character a cycle
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o
);
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end
  // every line is sent as given and ends in newline
  task automatic send_line(input string s);
    string t;
    t = {s, "\n"};
    for (int i = 0; i < t.len(); i++)
    begin
      @(posedge clk_i);
      rx_data_o <= t[i];
      rx_valid_o <= 1'b1;
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o; // idle line shows junk so stale data cannot pass
  endtask
endmodule
`default_nettype wire

// ---- tb/scpi_keyword_parser_tb_top.sv ----
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "keyword_parser_defines.vh"
module scpi_keyword_parser_tb_top;
  localparam logic [15:0] PWD = 16'h0457; // 1111 decimal, arbitrary access code
  localparam logic [15:0] MV = 16'h1A2B;
  localparam logic [15:0] MC = 16'h03C4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic get_i = 1'b0;
  logic panel_cal_i = 1'b0;
  logic [15:0] meas_volt_i = MV;
  logic [15:0] meas_curr_i = MC;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rx_data_i;
  logic rx_valid_i;
  logic [15:0] rdata_o;
  logic trigger_o;
  logic query_o;
  logic [31:0] resp_o;
  logic cal_busy_o;
  logic nv_we_o;
  logic [3:0] nv_addr_o;
  logic [15:0] nv_data_o;
  logic [7:0] error_o;
  logic [15:0] rd_val;
  int mismatches = 0;
  int samples_checked = 0;
  int n_trig;
  int n_qry;
  int n_nv;
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  keyword_parser #(.CAL_PASSWORD(PWD)) keyword_parser_i (.clk_i(clk_i), .rst_i(rst_i),
    .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .get_i(get_i),
    .panel_cal_i(panel_cal_i), .meas_volt_i(meas_volt_i), .meas_curr_i(meas_curr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .trigger_o(trigger_o), .query_o(query_o), .resp_o(resp_o), .cal_busy_o(cal_busy_o),
    .nv_we_o(nv_we_o), .nv_addr_o(nv_addr_o), .nv_data_o(nv_data_o), .error_o(error_o));
  host_model host_model_i (.clk_i(clk_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // register bus: one-cycle strobes, read data in the following cycle
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, exp, what);
  endtask
  // counts output pulses over a fixed window; bounded by construction
  task automatic watch(input int n);
    n_trig = 0;
    n_qry = 0;
    n_nv = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      if (trigger_o === 1'b1)
        n_trig++;
      if (nv_we_o === 1'b1)
        n_nv++;
      if (query_o === 1'b1)
      begin
        n_qry++;
        check(resp_o, {MV, MC}, "resp");
      end
    end
  endtask
  // err of FF skips the error code compare
  task automatic line(input string s, input int tr, input int q, input logic [7:0] err);
    fork
      host_model_i.send_line(s);
      watch(s.len() + 30);
    join
    check(n_trig, tr, s);
    check(n_qry, q, s);
    if (err !== 8'hFF)
      check(error_o, err, s);
    if (error_o !== `ERR_NONE)
      reg_wr(`A_ERROR, 16'h0000);
  endtask
  // group trigger pin: held past the three-flop synchroniser
  task automatic get_pulse(input int tr);
    fork
      begin
        @(posedge clk_i);
        get_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        get_i <= 1'b0;
      end
      watch(20);
    join
    check(n_trig, tr, "get");
  endtask
  task automatic t_regs();
    reg_rd(`A_ERROR, 16'h0000, "err rst");
    reg_rd(`A_ARMED, 16'h0000, "armed rst");
    reg_wr(4'hF, 16'hFFFF);
    reg_rd(4'hF, 16'h0000, "unmapped");
    reg_wr(`A_OPER_EN, 16'h00A5);
    reg_rd(`A_OPER_EN, 16'h00A5, "oper en");
    reg_wr(`A_QUES_EN, 16'h005A);
    reg_rd(`A_QUES_EN, 16'h005A, "ques en");
    reg_rd(`A_MEAS, MV, "meas");
    reg_wr(`A_LIST_IDX, 16'h00F9);
    reg_rd(`A_LIST_IDX, 16'h00F9, "list idx");
    $display("done regs");
  endtask
  task automatic t_trig();
    line("TRIG", 0, 0, `ERR_NONE);
    get_pulse(0);
    line("INIT", 0, 0, `ERR_NONE);
    line("trig", 1, 0, `ERR_NONE);
    line("*TRG", 1, 0, `ERR_NONE);
    line("TRIGGER", 1, 0, `ERR_NONE);
    get_pulse(1);
    reg_wr(`A_ARMED, 16'h0000);
    line("*TRG", 0, 0, `ERR_NONE);
    $display("done trig");
  endtask
  task automatic t_kw();
    line("MEAS:VOLT?", 0, 1, `ERR_NONE);
    line("measure:voltage?", 0, 1, `ERR_NONE);
    line("MeAs:CuRr?", 0, 1, `ERR_NONE);
    line("MEASU:VOLT?", 0, 0, `ERR_KEYWORD);
    line("MEAS:VOLTA?", 0, 0, `ERR_KEYWORD);
    line("INI", 0, 0, `ERR_KEYWORD);
    line("MEASU:VOLT?;:MEAS:VOLT?", 0, 0, `ERR_KEYWORD);
    line("MEAS:VOLT?;CURR?", 0, 2, `ERR_NONE);
    line(":MEAS:VOLT?;:MEAS:CURR?", 0, 2, `ERR_NONE);
    line("STATUS:OPERATION:ENABLE 7", 0, 0, `ERR_NONE);
    reg_rd(`A_OPER_EN, 16'h0007, "oper en");
    line("stat:ques:enab 3", 0, 0, `ERR_NONE);
    reg_rd(`A_QUES_EN, 16'h0003, "ques en");
    $display("done keywords");
  endtask
  task automatic t_list();
    line("LIST:DWEL 0", 0, 0, `ERR_RANGE);
    line("LIST:DWEL 65537", 0, 0, `ERR_RANGE);
    line("LIST:DWEL 65535", 0, 0, `ERR_NONE);
    line("LIS:DWEL 5", 0, 0, `ERR_KEYWORD);
    line("LIST:DWEL 1", 0, 0, `ERR_NONE);
    reg_rd(`A_LIST_TIME, 16'h0001, "dwell");
    $display("done list");
  endtask
  task automatic t_cal();
    panel_cal_i <= 1'b1;
    line("CAL:PASS 1111", 0, 0, 8'hFF);
    check(cal_busy_o, 1'b0, "panel");
    panel_cal_i <= 1'b0;
    line("CAL:PASS 2", 0, 0, 8'hFF);
    check(cal_busy_o, 1'b0, "bad pwd");
    line("CAL:PASS 1111", 0, 0, `ERR_NONE);
    check(cal_busy_o, 1'b1, "good pwd");
    line("CAL:VOLT:ZERO", 0, 0, `ERR_NONE);
    meas_volt_i <= MV + 16'h0100; // full-scale reading sits above the zero reading
    line("CAL:VOLT:LEV", 0, 0, `ERR_NONE);
    line("CAL:SAVE", 0, 0, `ERR_NONE);
    check(n_nv != 0, 1'b1, "nv write");
    check(nv_addr_o, 4'h3, "nv steps");
    check(nv_data_o, 16'h0100, "nv coef");
    check(cal_busy_o, 1'b0, "saved");
    $display("done cal");
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard well beyond the planned run
  initial
  begin
    #4ms;
    mismatches++;
    final_report();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_trig();
    t_kw();
    t_list();
    t_cal();
    final_report();
  end
endmodule
`default_nettype wire
